// ### sptmr_top.sv
// Supervision timer with APB registers, sleep handling and time-out reset or wake
//
// Notes on behaviour
// R1 - Counter advances on ticks of the slow internal oscillator, 1 ms unit.
// R2 - Mode 11: timer always active, also during sleep.
// R3 - Mode 10: active while awake, disabled during sleep.
// R4 - Mode 01: software enable bit decides; sleep does not change it.
// R5 - Mode 00: timer disabled whatever the enable bit or sleep state.
// R6 - Prescale field selects period from 1 ms to 256 s.
// R7 - After reset, prescale gives a two second period.
// R8 - Counter cleared on reset, clear instruction, sleep entry/exit, oscillator fail, disable.
// R9 - Wake with crystal clock holds counter clear until start-up timer ends.
// R10 - After sleep-entry clear, counting resumes if still enabled in sleep.
// R11 - Time-out in sleep wakes the device, no reset, updates both flags.
// R12 - Changing the internal oscillator divider leaves the counter alone.
// R13 - Time-out while awake and active resets the device, clears expiry flag.
`timescale 1ns/1ps
`include "sptmr_defines.svh"

module sptmr_top import sptmr_pkg::*; #(
    parameter int CNT_W = `SPTMR_CNT_W,
    parameter int TICKS_PER_UNIT = `SPTMR_OSC_KHZ * `SPTMR_UNIT_MS
) (
    input wire logic pclk, // APB and system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB direction
    input wire logic [`SPTMR_ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic low_freq_internal_osc, // slow oscillator level
    input wire logic [1:0] watchdog_mode_config, // configuration mode field
    input wire logic sleep_mode, // device is in sleep
    input wire logic clear_watchdog_instr, // clear instruction executed, pulse
    input wire logic osc_fail, // oscillator failure detected
    input wire logic crystal_clock_sel, // crystal system clock mode selected
    input wire logic osc_startup_timer, // start-up timer running
    output logic reset_req, // device reset request, pulse
    output logic wake_req, // wake from sleep request, pulse
    output logic expiry_flag, // low after a time-out
    output logic sleep_entered_flag, // low after sleep entry or sleep time-out
    output logic irq // level interrupt
);

    generate
        if (CNT_W < `SPTMR_PS_MAX + 1 || CNT_W > 32) begin : g_bad_width
            $error("CNT_W must cover the largest prescale and fit the read data");
        end
    endgenerate

    function automatic logic [CNT_W-1:0] last_count(input logic [`SPTMR_PS_W-1:0] ps);
        last_count = (CNT_W'(1) << ps) - CNT_W'(1);
    endfunction : last_count

    function automatic logic mode_active(input sptmr_mode_e mode, input logic en, input logic slp);
        unique case (mode)
            SPTMR_MODE_ON: mode_active = 1'b1; // see R2
            SPTMR_MODE_AWAKE: mode_active = ~slp; // see R3
            SPTMR_MODE_SW: mode_active = en; // see R4
            SPTMR_MODE_OFF: mode_active = 1'b0; // see R5
        endcase
    endfunction : mode_active

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    logic sw_en;
    logic [`SPTMR_PS_W-1:0] ps;
    logic [`SPTMR_EV_W-1:0] events;
    logic [`SPTMR_EV_W-1:0] next_events;
    logic [`SPTMR_EV_W-1:0] mask;
    logic [`SPTMR_EV_W-1:0] rd_events;
    logic [CNT_W-1:0] cnt;
    logic sleep_q;
    sptmr_state_e state;
    logic unit_tick;
    logic active;
    logic sleep_enter;
    logic sleep_exit;
    logic cmd_clr;
    logic clr_cnt;
    logic timeout;
    logic wr_acc;
    logic rd_acc;
    logic setup;
    logic mapped;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave, zero wait states

    assign setup = psel & ~penable;
    assign wr_acc = psel & penable & pready & pwrite;
    assign rd_acc = psel & penable & pready & ~pwrite;
    assign mapped = (paddr == `SPTMR_ADDR_CTRL) || (paddr == `SPTMR_ADDR_CMD) ||
                    (paddr == `SPTMR_ADDR_EVENT) || (paddr == `SPTMR_ADDR_MASK) ||
                    (paddr == `SPTMR_ADDR_STATE) || (paddr == `SPTMR_ADDR_COUNT);
    assign cmd_clr = wr_acc && (paddr == `SPTMR_ADDR_CMD) && pwdata[`SPTMR_CMD_CLR_BIT];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
        end
    end

    // Read data is captured in the setup cycle; the event bits captured are the only ones a read clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            rd_events <= '0;
        end else if (setup && !pwrite) begin
            prdata <= 32'h0;
            rd_events <= '0;
            unique case (paddr)
                `SPTMR_ADDR_CTRL: begin
                    prdata[`SPTMR_CTRL_EN_BIT] <= sw_en;
                    prdata[`SPTMR_CTRL_PS_MSB:`SPTMR_CTRL_PS_LSB] <= ps;
                end
                `SPTMR_ADDR_EVENT: begin
                    prdata[`SPTMR_EV_W-1:0] <= events;
                    rd_events <= events;
                end
                `SPTMR_ADDR_MASK: prdata[`SPTMR_EV_W-1:0] <= mask;
                `SPTMR_ADDR_STATE: begin
                    prdata[`SPTMR_ST_EXPIRY] <= expiry_flag;
                    prdata[`SPTMR_ST_SLEPT] <= sleep_entered_flag;
                    prdata[`SPTMR_ST_ACTIVE] <= active;
                    prdata[`SPTMR_ST_SLEEP] <= sleep_q;
                end
                `SPTMR_ADDR_COUNT: prdata[CNT_W-1:0] <= cnt;
                default: prdata <= 32'h0;
            endcase
        end else begin
            prdata <= 32'h0;
            rd_events <= '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sw_en <= 1'b0;
            ps <= `SPTMR_PS_RESET; // see R7
        end else if (wr_acc && paddr == `SPTMR_ADDR_CTRL) begin
            sw_en <= pwdata[`SPTMR_CTRL_EN_BIT];
            // Periods beyond 256 s are not offered; larger codes saturate
            if (pwdata[`SPTMR_CTRL_PS_MSB:`SPTMR_CTRL_PS_LSB] > `SPTMR_PS_MAX) begin
                ps <= `SPTMR_PS_MAX; // see R6
            end else begin
                ps <= pwdata[`SPTMR_CTRL_PS_MSB:`SPTMR_CTRL_PS_LSB]; // see R6
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask <= '0;
        end else if (wr_acc && paddr == `SPTMR_ADDR_MASK) begin
            mask <= pwdata[`SPTMR_EV_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sleep tracking and post-wake hold

    assign sleep_enter = sleep_mode & ~sleep_q;
    assign sleep_exit = ~sleep_mode & sleep_q;
    assign active = mode_active(sptmr_mode_e'(watchdog_mode_config), sw_en, sleep_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sleep_q <= 1'b0;
        end else begin
            sleep_q <= sleep_mode;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= SPTMR_RUN;
        end else begin
            unique case (state)
                SPTMR_RUN: if (sleep_exit && crystal_clock_sel) begin
                    state <= SPTMR_HOLD; // see R9
                end
                SPTMR_HOLD: if (!osc_startup_timer) begin
                    state <= SPTMR_RUN;
                end
                default: state <= SPTMR_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time-out counter

    // No divider-select term here: retuning the system oscillator must not clear the count - see R12
    assign clr_cnt = clear_watchdog_instr | cmd_clr | sleep_enter | sleep_exit | osc_fail |
                     ~active | (state == SPTMR_HOLD); // see R8
    assign timeout = active & unit_tick & ~clr_cnt & (cnt == last_count(ps));

    sptmr_tick #(
        .TICKS_PER_UNIT(TICKS_PER_UNIT)
    ) u_tick (
        .pclk(pclk),
        .presetn(presetn),
        .low_freq_internal_osc(low_freq_internal_osc),
        .restart(clr_cnt | timeout),
        .unit_tick(unit_tick)
    );

    // After a sleep-entry clear the count simply resumes when still active - see R10
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= '0; // see R8
        end else if (clr_cnt || timeout) begin
            cnt <= '0;
        end else if (unit_tick) begin
            cnt <= cnt + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Time-out effects and status flags

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            reset_req <= 1'b0;
            wake_req <= 1'b0;
        end else begin
            reset_req <= timeout & ~sleep_q; // see R13
            wake_req <= timeout & sleep_q; // see R11
        end
    end

    // Flags idle high; the clear instruction restores both unless sleep entry falls in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            expiry_flag <= 1'b1;
            sleep_entered_flag <= 1'b1;
        end else if (timeout) begin
            expiry_flag <= 1'b0; // see R11, R13
            sleep_entered_flag <= sleep_entered_flag & ~sleep_q; // see R11
        end else if (sleep_enter) begin
            sleep_entered_flag <= 1'b0;
        end else if (clear_watchdog_instr || cmd_clr) begin
            expiry_flag <= 1'b1;
            sleep_entered_flag <= 1'b1;
        end
    end

    always_comb begin
        next_events = events;
        if (rd_acc && paddr == `SPTMR_ADDR_EVENT) begin
            next_events = events & ~rd_events;
        end
        // A new event wins over the read-clear in the same cycle
        next_events[`SPTMR_EV_AWAKE] = next_events[`SPTMR_EV_AWAKE] | (timeout & ~sleep_q);
        next_events[`SPTMR_EV_SLEEP] = next_events[`SPTMR_EV_SLEEP] | (timeout & sleep_q);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            events <= '0;
            irq <= 1'b0;
        end else begin
            events <= next_events;
            irq <= |(next_events & mask);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    awake_reset_a: assert property (timeout && !sleep_q |=> reset_req && !wake_req && !expiry_flag) // see R13
        else $error("awake time-out did not reset");
    sleep_wake_a: assert property (timeout && sleep_q |=> wake_req && !reset_req && !sleep_entered_flag) // see R11
        else $error("sleep time-out did not wake");
    mode_on_a: assert property (watchdog_mode_config == 2'h3 |-> active) // see R2
        else $error("mode 11 not active");
    mode_awake_a: assert property (watchdog_mode_config == 2'h2 |-> active == !sleep_q) // see R3
        else $error("mode 10 wrong in sleep");
    mode_sw_a: assert property (watchdog_mode_config == 2'h1 |-> active == sw_en) // see R4
        else $error("mode 01 ignores enable");
    mode_off_a: assert property (watchdog_mode_config == 2'h0 |=> cnt == '0 && !reset_req) // see R5
        else $error("mode 00 still counting");
    clear_instr_a: assert property (clear_watchdog_instr || osc_fail || sleep_enter |=> cnt == '0) // see R8
        else $error("counter not cleared");
    wake_hold_a: assert property (state == SPTMR_HOLD |=> // see R9
        cnt == '0 && (state == SPTMR_RUN || $past(osc_startup_timer)))
        else $error("hold after wake broken");
    period_hit_a: assert property (timeout |-> cnt == last_count(ps) && ps <= `SPTMR_PS_MAX) // see R6
        else $error("time-out at wrong count");
    resume_a: assert property (unit_tick && !clr_cnt && !timeout && sleep_q |=> cnt == $past(cnt) + 1'b1) // see R10
        else $error("count did not resume in sleep");

    awake_timeout_c: cover property (reset_req);
    sleep_timeout_c: cover property (wake_req);
    hold_c: cover property (state == SPTMR_HOLD ##1 state == SPTMR_RUN);
    read_clear_c: cover property (rd_acc && paddr == `SPTMR_ADDR_EVENT && |rd_events);

endmodule : sptmr_top

// ### sptmr_defines.svh
// Register map, field positions, reset values and timing figures of the supervision timer
`ifndef SPTMR_DEFINES_SVH
`define SPTMR_DEFINES_SVH

`define SPTMR_ADDR_W 8
`define SPTMR_ADDR_CTRL 8'h00
`define SPTMR_ADDR_CMD 8'h04
`define SPTMR_ADDR_EVENT 8'h08
`define SPTMR_ADDR_MASK 8'h0C
`define SPTMR_ADDR_STATE 8'h10
`define SPTMR_ADDR_COUNT 8'h14

`define SPTMR_CTRL_EN_BIT 0
`define SPTMR_CTRL_PS_LSB 1
`define SPTMR_CTRL_PS_MSB 5
`define SPTMR_PS_W 5
`define SPTMR_PS_RESET 5'h0B
`define SPTMR_PS_MAX 5'h12

`define SPTMR_CMD_CLR_BIT 0

`define SPTMR_EV_W 2
`define SPTMR_EV_AWAKE 0
`define SPTMR_EV_SLEEP 1

`define SPTMR_ST_EXPIRY 0
`define SPTMR_ST_SLEPT 1
`define SPTMR_ST_ACTIVE 2
`define SPTMR_ST_SLEEP 3

`define SPTMR_CNT_W 19
`define SPTMR_OSC_KHZ 31
`define SPTMR_UNIT_MS 1

`endif

// ### sptmr_pkg.sv
// Types shared by the supervision timer modules
package sptmr_pkg;

    typedef enum logic [1:0] {
        SPTMR_MODE_OFF = 2'h0,
        SPTMR_MODE_SW = 2'h1,
        SPTMR_MODE_AWAKE = 2'h2,
        SPTMR_MODE_ON = 2'h3
    } sptmr_mode_e;

    typedef enum logic [1:0] {
        SPTMR_RUN = 2'b01,
        SPTMR_HOLD = 2'b10
    } sptmr_state_e;

endpackage : sptmr_pkg

// ### sptmr_tick.sv
// Unit tick generator counting edges of the low-frequency internal oscillator
`timescale 1ns/1ps
`include "sptmr_defines.svh"

module sptmr_tick import sptmr_pkg::*; #(
    parameter int TICKS_PER_UNIT = `SPTMR_OSC_KHZ * `SPTMR_UNIT_MS
) (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic low_freq_internal_osc, // oscillator level, sampled
    input wire logic restart, // restart the unit phase
    output logic unit_tick // one pulse per time unit
);

    localparam int DW = (TICKS_PER_UNIT > 1) ? $clog2(TICKS_PER_UNIT) : 1;
    localparam logic [DW-1:0] LAST = DW'(TICKS_PER_UNIT - 1);

    generate
        if (TICKS_PER_UNIT < 1) begin : g_bad_ticks
            $error("TICKS_PER_UNIT must be at least one");
        end
    endgenerate

    logic osc_q;
    logic [DW-1:0] div;
    logic osc_edge;

    assign osc_edge = low_freq_internal_osc & ~osc_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_q <= 1'b0;
        end else begin
            osc_q <= low_freq_internal_osc;
        end
    end

    // Time base comes only from the slow oscillator, never from pclk itself - see R1
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div <= '0;
            unit_tick <= 1'b0;
        end else if (restart) begin
            div <= '0;
            unit_tick <= 1'b0;
        end else if (osc_edge) begin
            div <= (div == LAST) ? '0 : div + 1'b1;
            unit_tick <= (div == LAST);
        end else begin
            unit_tick <= 1'b0;
        end
    end

    tick_single_a: assert property (@(posedge pclk) disable iff (!presetn) unit_tick |=> !unit_tick) // see R1
        else $error("unit tick longer than one cycle");

endmodule : sptmr_tick

// ### sptmr_top_tb.sv
// Self-checking bench for the supervision timer
`timescale 1ns/1ps
`include "sptmr_defines.svh"

module sptmr_top_tb import sptmr_pkg::*; ();
    localparam int UNIT = 8; // pclk cycles per unit: oscillator period 4, two edges per unit
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [`SPTMR_ADDR_W-1:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, reset_req, wake_req, expiry_flag, sleep_entered_flag, irq;
    logic low_freq_internal_osc = 1'b0;
    logic [1:0] watchdog_mode_config = 2'h0;
    logic sleep_mode = 1'b0;
    logic clear_watchdog_instr = 1'b0;
    logic osc_fail = 1'b0;
    logic crystal_clock_sel = 1'b0;
    logic osc_startup_timer = 1'b0;
    logic [1:0] osc_div = 2'h0;
    logic [31:0] rdat;
    logic rerr;
    int fail_count = 0;
    int n_checks = 0;
    int n_rst = 0;
    int n_wake = 0;

    sptmr_top #(.CNT_W(19), .TICKS_PER_UNIT(2)) sptmr_top_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .low_freq_internal_osc(low_freq_internal_osc), .watchdog_mode_config(watchdog_mode_config),
        .sleep_mode(sleep_mode), .clear_watchdog_instr(clear_watchdog_instr), .osc_fail(osc_fail),
        .crystal_clock_sel(crystal_clock_sel), .osc_startup_timer(osc_startup_timer),
        .reset_req(reset_req), .wake_req(wake_req), .expiry_flag(expiry_flag),
        .sleep_entered_flag(sleep_entered_flag), .irq(irq)
    );

    always #4 pclk = ~pclk;

    // Slow oscillator kept synchronous so unit length is exact
    always @(posedge pclk) begin
        osc_div <= osc_div + 2'h1;
        low_freq_internal_osc <= osc_div[1];
    end

    always @(posedge pclk) begin
        if (reset_req === 1'b1) n_rst++;
        if (wake_req === 1'b1) n_wake++;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    task automatic chk_bit(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %b, seen %b", what, exp, got);
        end
    endtask : chk_bit

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk_word

    task automatic idle(input int n);
        repeat (n) @(posedge pclk);
    endtask : idle

    // Leading edge keeps the release of one transfer apart from the next setup
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        chk_bit("apb wait states", 1'b1, n == 1);
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic clr_pulse();
        clear_watchdog_instr <= 1'b1;
        @(posedge pclk);
        clear_watchdog_instr <= 1'b0;
    endtask : clr_pulse

    task automatic wait_pulse(input logic wake, input int lim, output int lat);
        lat = 0;
        do begin
            @(posedge pclk);
            lat++;
        end while ((wake ? wake_req : reset_req) !== 1'b1 && lat < lim);
    endtask : wait_pulse

    function automatic logic [31:0] exp_ctrl(input logic [4:0] ps, input logic en);
        return {26'h0, (ps > 5'h12) ? 5'h12 : ps, en};
    endfunction : exp_ctrl

    function automatic logic exp_active(input logic [1:0] m, input logic en, input logic s);
        case (m)
            2'h3: return 1'b1;
            2'h2: return !s;
            2'h1: return en;
            default: return 1'b0;
        endcase
    endfunction : exp_active

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        #(8 * 30000);
        fail_count++;
        conclude();
    end

    initial begin
        int lat;
        int c0;
        logic [4:0] ps;
        logic en;
        logic [4:0] corner [4];
        corner = '{5'h00, 5'h12, 5'h13, 5'h1F};
        void'($urandom(28872));
        idle(8);
        presetn <= 1'b1;
        apb(1'b0, `SPTMR_ADDR_CTRL, 32'h0);
        chk_word("ctrl reset", 32'h16, rdat);
        apb(1'b0, `SPTMR_ADDR_STATE, 32'h0);
        chk_word("state reset", 32'h3, rdat);
        apb(1'b0, 8'h18, 32'h0);
        chk_bit("unmapped err", 1'b1, rerr);
        chk_word("unmapped data", 32'h0, rdat);
        for (int i = 0; i < 12; i++) begin
            ps = (i < 4) ? corner[i] : 5'($urandom_range(31));
            en = 1'($urandom_range(1));
            apb(1'b1, `SPTMR_ADDR_CTRL, {26'h0, ps, en});
            apb(1'b0, `SPTMR_ADDR_CTRL, 32'h0);
            chk_word("ctrl prescale", exp_ctrl(ps, en), rdat);
        end
        for (int k = 0; k < 16; k++) begin
            watchdog_mode_config <= k[3:2];
            sleep_mode <= k[1];
            apb(1'b1, `SPTMR_ADDR_CTRL, {26'h0, 5'h0B, k[0]});
            idle(3 * UNIT);
            apb(1'b0, `SPTMR_ADDR_STATE, 32'h0);
            chk_bit("active", exp_active(k[3:2], k[0], k[1]), rdat[`SPTMR_ST_ACTIVE]);
            chk_bit("sleeping", k[1], rdat[`SPTMR_ST_SLEEP]);
            apb(1'b0, `SPTMR_ADDR_COUNT, 32'h0);
            chk_bit("count runs", exp_active(k[3:2], k[0], k[1]), rdat != 32'h0);
        end
        // Awake time-out, ps 2 gives four units
        sleep_mode <= 1'b0;
        watchdog_mode_config <= SPTMR_MODE_OFF;
        apb(1'b1, `SPTMR_ADDR_MASK, 32'h1);
        apb(1'b1, `SPTMR_ADDR_CTRL, 32'h4);
        watchdog_mode_config <= SPTMR_MODE_ON;
        clr_pulse();
        wait_pulse(1'b0, 20 * UNIT, lat);
        chk_bit("awake latency", 1'b1, lat >= 3 * UNIT && lat <= 5 * UNIT);
        chk_bit("expiry flag", 1'b0, expiry_flag);
        chk_bit("sleep flag", 1'b1, sleep_entered_flag);
        chk_bit("irq raised", 1'b1, irq);
        apb(1'b0, `SPTMR_ADDR_EVENT, 32'h0);
        chk_word("event awake", 32'h1, rdat);
        watchdog_mode_config <= SPTMR_MODE_OFF;
        idle(2);
        chk_bit("irq cleared", 1'b0, irq);
        clr_pulse();
        idle(2);
        chk_bit("flag after clear", 1'b1, expiry_flag);
        // Sleep time-out with its event masked
        sleep_mode <= 1'b1;
        watchdog_mode_config <= SPTMR_MODE_ON;
        c0 = n_rst;
        wait_pulse(1'b1, 20 * UNIT, lat);
        chk_bit("sleep latency", 1'b1, lat >= 3 * UNIT && lat <= 5 * UNIT);
        chk_bit("no reset asleep", 1'b1, n_rst == c0);
        chk_bit("expiry sleep", 1'b0, expiry_flag);
        chk_bit("sleep flag sleep", 1'b0, sleep_entered_flag);
        chk_bit("irq masked", 1'b0, irq);
        apb(1'b0, `SPTMR_ADDR_EVENT, 32'h0);
        chk_word("event sleep", 32'h2, rdat);
        watchdog_mode_config <= SPTMR_MODE_OFF;
        apb(1'b1, `SPTMR_ADDR_CMD, 32'h1);
        idle(2);
        chk_bit("flags after cmd", 1'b1, expiry_flag & sleep_entered_flag);
        // Mode 10 stays quiet in sleep, one unit period
        apb(1'b1, `SPTMR_ADDR_CTRL, 32'h0);
        idle(2);
        c0 = n_wake + n_rst;
        watchdog_mode_config <= SPTMR_MODE_AWAKE;
        idle(12 * UNIT);
        chk_bit("quiet asleep", 1'b1, n_wake + n_rst == c0);
        sleep_mode <= 1'b0;
        wait_pulse(1'b0, 4 * UNIT, lat);
        chk_bit("awake again", 1'b1, lat < 4 * UNIT);
        watchdog_mode_config <= SPTMR_MODE_OFF;
        // Counting rate, sleep clears and the crystal start-up hold
        apb(1'b1, `SPTMR_ADDR_CTRL, 32'h14);
        watchdog_mode_config <= SPTMR_MODE_ON;
        clr_pulse();
        idle(10 * UNIT);
        apb(1'b0, `SPTMR_ADDR_COUNT, 32'h0);
        chk_bit("unit rate", 1'b1, rdat inside {[32'h8:32'hB]});
        sleep_mode <= 1'b1;
        crystal_clock_sel <= 1'b1;
        osc_startup_timer <= 1'b1;
        idle(4 * UNIT);
        apb(1'b0, `SPTMR_ADDR_COUNT, 32'h0);
        chk_bit("counts asleep", 1'b1, rdat inside {[32'h2:32'h5]});
        sleep_mode <= 1'b0;
        idle(10 * UNIT);
        apb(1'b0, `SPTMR_ADDR_COUNT, 32'h0);
        chk_word("startup hold", 32'h0, rdat);
        osc_startup_timer <= 1'b0;
        idle(4 * UNIT);
        apb(1'b0, `SPTMR_ADDR_COUNT, 32'h0);
        chk_bit("hold released", 1'b1, rdat inside {[32'h2:32'h5]});
        osc_fail <= 1'b1;
        idle(4 * UNIT);
        apb(1'b0, `SPTMR_ADDR_COUNT, 32'h0);
        chk_word("osc fail", 32'h0, rdat);
        osc_fail <= 1'b0;
        crystal_clock_sel <= 1'b0;
        sleep_mode <= 1'b1;
        idle(4 * UNIT);
        sleep_mode <= 1'b0;
        idle(2 * UNIT);
        apb(1'b0, `SPTMR_ADDR_COUNT, 32'h0);
        chk_bit("single clear", 1'b1, rdat inside {[32'h1:32'h3]});
        // Reset in mid-run restores the default period
        watchdog_mode_config <= SPTMR_MODE_OFF;
        presetn <= 1'b0;
        idle(2);
        presetn <= 1'b1;
        apb(1'b0, `SPTMR_ADDR_CTRL, 32'h0);
        chk_word("ctrl second reset", 32'h16, rdat);
        conclude();
    end
endmodule : sptmr_top_tb
